// [pwm_timer_map.svh]
// Register offsets, field positions, reset values and prescale counts of the dual-slope PWM timer
// Included by the package-using timer modules; definitions only
`ifndef PWM_TIMER_MAP_SVH
`define PWM_TIMER_MAP_SVH

`define TIMER_CONTROL_A_OFFSET      8'h2f
`define TIMER_CONTROL_B_OFFSET      8'h30
`define COUNTER_VALUE_LO_OFFSET     8'h31
`define COUNTER_VALUE_HI_OFFSET     8'h32
`define COMPARE_VALUE_A_LO_OFFSET   8'h33
`define COMPARE_VALUE_A_HI_OFFSET   8'h34
`define COMPARE_VALUE_B_LO_OFFSET   8'h35
`define COMPARE_VALUE_B_HI_OFFSET   8'h36
`define INPUT_CAPTURE_LO_OFFSET     8'h37
`define INPUT_CAPTURE_HI_OFFSET     8'h38
`define TIMER_FLAGS_OFFSET          8'h39
`define OUTPUT_DIRECTION_OFFSET     8'h3a

`define CMODE_A_POS                 6
`define CMODE_B_POS                 4
`define WMODE_LOW_POS               0
`define WMODE_HIGH_POS              3
`define CLOCK_SELECT_POS            0

`define FLAG_OVERFLOW_POS           0
`define FLAG_MATCH_A_POS            1
`define FLAG_MATCH_B_POS            2
`define FLAG_CAPTURE_POS            5

`define CONTROL_RESET               8'h00
`define WORD_RESET                  16'h0000
`define BOTTOM_VALUE                16'h0000

`define PRESCALE_8                  10'h007
`define PRESCALE_64                 10'h03f
`define PRESCALE_256                10'h0ff
`define PRESCALE_1024               10'h3ff

`endif

// [pwm_timer_pkg.sv]
// Types shared by the dual-slope PWM timer modules
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package pwm_timer_pkg;
	typedef logic [3:0] wave_mode_t;
	typedef logic [1:0] out_mode_t;
	typedef enum logic [2:0] {
		TICK_STOP  = 3'b000,
		TICK_DIV1  = 3'b001,
		TICK_DIV8  = 3'b010,
		TICK_DIV64 = 3'b011,
		TICK_DIV256 = 3'b100,
		TICK_DIV1024 = 3'b101,
		TICK_EXT_F = 3'b110,
		TICK_EXT_R = 3'b111
	} tick_select_e;
	localparam wave_mode_t MODE_TOP_CAPTURE = 4'h8;
	localparam wave_mode_t MODE_TOP_COMPARE = 4'h9;
	localparam out_mode_t  OUT_TOGGLE = 2'h1;
	localparam out_mode_t  OUT_NONINV = 2'h2;
	localparam out_mode_t  OUT_INV    = 2'h3;
endpackage
`default_nettype wire

// [timer_prescaler.sv]
// Prescaler producing the one-cycle timer tick enable
// Assumes clk_i is the I/O clock; external tick selections give no tick
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.svh"
module timer_prescaler (
	input  wire logic                        clk_i,
	input  wire logic                        reset_i,
	input  wire pwm_timer_pkg::tick_select_e select_i,
	output logic                             tick_o
);
	import pwm_timer_pkg::*;

	logic [9:0] count;
	logic       next_tick;

	always_ff @(posedge clk_i) begin
		if (reset_i || select_i == TICK_STOP)
			count <= 10'h000;
		else
			count <= count + 10'h001;
	end

	// Tick on the last count of each divided period
	always_comb begin
		unique case (select_i)
			TICK_DIV1:    next_tick = 1'b1;
			TICK_DIV8:    next_tick = (count[2:0] == 3'(`PRESCALE_8));
			TICK_DIV64:   next_tick = (count[5:0] == 6'(`PRESCALE_64));
			TICK_DIV256:  next_tick = (count[7:0] == 8'(`PRESCALE_256));
			TICK_DIV1024: next_tick = (count == `PRESCALE_1024);
			default:      next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			tick_o <= 1'b0;
		else
			tick_o <= next_tick && select_i != TICK_STOP;
	end
endmodule // timer_prescaler
`default_nettype wire

// [pwm_timer.sv]
// Sixteen-bit timer in phase and frequency correct PWM operation
// Assumes a plain register port; the pins are external and resolved outside
//
// Contract
// - Modes 8 and 9 select dual-slope PWM
// - Count up to top, then down to zero
// - Non-inverting: clear upcounting match, set downcounting
// - Top from capture (8) or compare A (9)
// - Counter holds top for one tick
// - Compare match sets channel flag
// - Overflow flag set at bottom with reload
// - Top sets compare A or capture flag
// - Compare registers reload only at bottom
// - Mode two non-inverted, three inverted
// - Pin driven only with direction output
// - Frequency is clock over 2 N top
// - Compare zero low, compare top high; inverted mode gives the opposite
// - Tick is only a clock enable
// - Mode built from both control registers
// - Mode one toggles A; B reserved
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.svh"
module pwm_timer (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] address_i,
	input  wire logic [7:0] write_data_i,
	input  wire logic       write_i,
	input  wire logic       read_i,
	output logic      [7:0] read_data_o,
	output logic            compare_output_a_o,
	output logic            compare_output_a_oe_o,
	output logic            compare_output_b_o,
	output logic            compare_output_b_oe_o
);
	import pwm_timer_pkg::*;

	logic [7:0]  timer_control_a;
	logic [7:0]  timer_control_b;
	logic [15:0] counter_value;
	logic [15:0] compare_value_a;
	logic [15:0] compare_value_b;
	logic [15:0] buffer_a;
	logic [15:0] buffer_b;
	logic [15:0] input_capture_value;
	logic [7:0]  temp_high;
	logic [1:0]  output_direction_bit;
	logic        counting_down;
	logic        overflow_flag;
	logic        match_flag_a;
	logic        match_flag_b;
	logic        capture_flag;
	logic        level_a;
	logic        level_b;
	logic        timer_tick;
	wave_mode_t  waveform_mode_select;
	out_mode_t   compare_output_mode_a;
	out_mode_t   compare_output_mode_b;
	logic        dual_slope;
	logic [15:0] top_value;
	logic        at_top;
	logic        at_bottom;
	logic        match_a;
	logic        match_b;
	logic        wr_flags;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	// Next level of one channel on a match
	function automatic logic next_level(input out_mode_t mode, input logic down,
		input logic level, input logic toggle_ok);
		unique case (mode)
			OUT_NONINV: return down;
			OUT_INV:    return !down;
			OUT_TOGGLE: return toggle_ok ? !level : level;
			default:    return level;
		endcase
	endfunction

	assign waveform_mode_select = {timer_control_b[`WMODE_HIGH_POS +: 2],
		timer_control_a[`WMODE_LOW_POS +: 2]};
	assign compare_output_mode_a = timer_control_a[`CMODE_A_POS +: 2];
	assign compare_output_mode_b = timer_control_a[`CMODE_B_POS +: 2];
	assign dual_slope = waveform_mode_select == MODE_TOP_CAPTURE ||
		waveform_mode_select == MODE_TOP_COMPARE;
	assign top_value = (waveform_mode_select == MODE_TOP_CAPTURE) ?
		input_capture_value : compare_value_a;
	assign at_top    = dual_slope && counter_value == top_value;
	assign at_bottom = dual_slope && counter_value == `BOTTOM_VALUE;
	assign match_a   = dual_slope && counter_value == compare_value_a;
	assign match_b   = dual_slope && counter_value == compare_value_b;
	assign wr_flags  = write_i && hit(address_i, `TIMER_FLAGS_OFFSET);

	timer_prescaler timer_prescaler_i (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.select_i (tick_select_e'(timer_control_b[`CLOCK_SELECT_POS +: 3])),
		.tick_o   (timer_tick)
	);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			timer_control_a <= `CONTROL_RESET;
			timer_control_b <= `CONTROL_RESET;
			output_direction_bit <= 2'h0;
		end else if (write_i) begin
			if (hit(address_i, `TIMER_CONTROL_A_OFFSET))
				timer_control_a <= write_data_i & 8'hf3;
			if (hit(address_i, `TIMER_CONTROL_B_OFFSET))
				timer_control_b <= write_data_i & 8'h1f;
			if (hit(address_i, `OUTPUT_DIRECTION_OFFSET))
				output_direction_bit <= write_data_i[1:0];
		end
	end

	// High byte latched first, word committed on low byte write
	always_ff @(posedge clk_i) begin
		if (reset_i)
			temp_high <= 8'h00;
		else if (write_i && address_i[0] == 1'b0 && address_i >= `COUNTER_VALUE_HI_OFFSET
			&& address_i <= `INPUT_CAPTURE_HI_OFFSET)
			temp_high <= write_data_i;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			buffer_a <= `WORD_RESET;
			buffer_b <= `WORD_RESET;
			input_capture_value <= `WORD_RESET;
		end else if (write_i) begin
			if (hit(address_i, `COMPARE_VALUE_A_LO_OFFSET))
				buffer_a <= {temp_high, write_data_i};
			if (hit(address_i, `COMPARE_VALUE_B_LO_OFFSET))
				buffer_b <= {temp_high, write_data_i};
			if (hit(address_i, `INPUT_CAPTURE_LO_OFFSET))
				input_capture_value <= {temp_high, write_data_i};
		end
	end

	// Reload only at bottom keeps both slopes equal; outside PWM the write is immediate
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			compare_value_a <= `WORD_RESET;
			compare_value_b <= `WORD_RESET;
		end else if (!dual_slope) begin
			compare_value_a <= buffer_a;
			compare_value_b <= buffer_b;
		end else if (timer_tick && at_bottom) begin
			compare_value_a <= buffer_a;
			compare_value_b <= buffer_b;
		end
	end

	// Software write of the counter wins over counting
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			counter_value <= `WORD_RESET;
			counting_down <= 1'b0;
		end else if (write_i && hit(address_i, `COUNTER_VALUE_LO_OFFSET)) begin
			counter_value <= {temp_high, write_data_i};
		end else if (timer_tick && dual_slope) begin
			if (at_top) begin
				counting_down <= 1'b1;
				counter_value <= counter_value - 16'h0001;
			end else if (at_bottom) begin
				counting_down <= 1'b0;
				counter_value <= counter_value + 16'h0001;
			end else if (counting_down)
				counter_value <= counter_value - 16'h0001;
			else
				counter_value <= counter_value + 16'h0001;
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			overflow_flag <= 1'b0;
			match_flag_a  <= 1'b0;
			match_flag_b  <= 1'b0;
			capture_flag  <= 1'b0;
		end else begin
			overflow_flag <= (timer_tick && at_bottom) ||
				(overflow_flag && !(wr_flags && write_data_i[`FLAG_OVERFLOW_POS]));
			match_flag_a <= (timer_tick && match_a) ||
				(match_flag_a && !(wr_flags && write_data_i[`FLAG_MATCH_A_POS]));
			match_flag_b <= (timer_tick && match_b) ||
				(match_flag_b && !(wr_flags && write_data_i[`FLAG_MATCH_B_POS]));
			capture_flag <= (timer_tick && at_top &&
				waveform_mode_select == MODE_TOP_CAPTURE) ||
				(capture_flag && !(wr_flags && write_data_i[`FLAG_CAPTURE_POS]));
		end
	end

	// Match at zero sets low and at top sets high in non-inverting mode, giving the flat extremes
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			level_a <= 1'b0;
			level_b <= 1'b0;
		end else if (timer_tick) begin
			if (match_a)
				level_a <= next_level(compare_output_mode_a, counting_down && !at_bottom
					|| at_top, level_a, waveform_mode_select[3]);
			if (match_b)
				level_b <= next_level(compare_output_mode_b, counting_down && !at_bottom
					|| at_top, level_b, 1'b0);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			compare_output_a_o    <= 1'b0;
			compare_output_a_oe_o <= 1'b0;
			compare_output_b_o    <= 1'b0;
			compare_output_b_oe_o <= 1'b0;
		end else begin
			compare_output_a_o    <= level_a;
			compare_output_b_o    <= level_b;
			compare_output_a_oe_o <= compare_output_mode_a != 2'h0 && output_direction_bit[0];
			compare_output_b_oe_o <= compare_output_mode_b != 2'h0 && output_direction_bit[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			read_data_o <= 8'h00;
		else if (read_i) begin
			unique case (address_i)
				`TIMER_CONTROL_A_OFFSET:    read_data_o <= timer_control_a;
				`TIMER_CONTROL_B_OFFSET:    read_data_o <= timer_control_b;
				`COUNTER_VALUE_LO_OFFSET:   read_data_o <= counter_value[7:0];
				`COUNTER_VALUE_HI_OFFSET:   read_data_o <= counter_value[15:8];
				`COMPARE_VALUE_A_LO_OFFSET: read_data_o <= buffer_a[7:0];
				`COMPARE_VALUE_A_HI_OFFSET: read_data_o <= buffer_a[15:8];
				`COMPARE_VALUE_B_LO_OFFSET: read_data_o <= buffer_b[7:0];
				`COMPARE_VALUE_B_HI_OFFSET: read_data_o <= buffer_b[15:8];
				`INPUT_CAPTURE_LO_OFFSET:   read_data_o <= input_capture_value[7:0];
				`INPUT_CAPTURE_HI_OFFSET:   read_data_o <= input_capture_value[15:8];
				`TIMER_FLAGS_OFFSET:        read_data_o <= {2'h0, capture_flag, 2'h0,
					match_flag_b, match_flag_a, overflow_flag};
				`OUTPUT_DIRECTION_OFFSET:   read_data_o <= {6'h00, output_direction_bit};
				default:                    read_data_o <= 8'h00;
			endcase
		end else
			read_data_o <= 8'h00;
	end

	sequence s_top_tick;
		timer_tick && at_top && !write_i;
	endsequence

	sequence s_bottom_tick;
		timer_tick && at_bottom && !write_i;
	endsequence

	a_top_reverses: assert property (@(posedge clk_i) disable iff (reset_i)
		s_top_tick |=> counting_down) else $error("no reversal at top");
	a_top_one_tick: assert property (@(posedge clk_i) disable iff (reset_i)
		s_top_tick |=> counter_value == $past(counter_value) - 16'h0001)
		else $error("top held more than one tick");
	a_bottom_counts_up: assert property (@(posedge clk_i) disable iff (reset_i)
		s_bottom_tick |=> counter_value == 16'h0001 && !counting_down)
		else $error("bad turn at bottom");
	a_overflow_bottom: assert property (@(posedge clk_i) disable iff (reset_i)
		timer_tick && at_bottom |=> overflow_flag) else $error("overflow flag missed");
	a_reload_bottom: assert property (@(posedge clk_i) disable iff (reset_i)
		dual_slope && $changed(compare_value_b) |-> $past(timer_tick && at_bottom))
		else $error("compare reloaded off bottom");
	a_match_flag: assert property (@(posedge clk_i) disable iff (reset_i)
		timer_tick && match_b |=> match_flag_b) else $error("match flag missed");
	a_capture_top: assert property (@(posedge clk_i) disable iff (reset_i)
		(s_top_tick and waveform_mode_select == MODE_TOP_CAPTURE) |=> capture_flag)
		else $error("capture flag missed");
	a_compare_top: assert property (@(posedge clk_i) disable iff (reset_i)
		(s_top_tick and waveform_mode_select == MODE_TOP_COMPARE) |=> match_flag_a)
		else $error("top flag missed");
	a_pin_direction: assert property (@(posedge clk_i) disable iff (reset_i)
		!output_direction_bit[0] |=> !compare_output_a_oe_o)
		else $error("pin driven as input");
	a_pin_direction_b: assert property (@(posedge clk_i) disable iff (reset_i)
		!output_direction_bit[1] |=> !compare_output_b_oe_o)
		else $error("pin driven as input");
	a_noninv_up: assert property (@(posedge clk_i) disable iff (reset_i)
		timer_tick && match_b && !counting_down && !at_top &&
		compare_output_mode_b == OUT_NONINV |=> !level_b ##1 !compare_output_b_o)
		else $error("up match did not clear");
	a_noninv_down: assert property (@(posedge clk_i) disable iff (reset_i)
		timer_tick && match_b && counting_down && !at_bottom &&
		compare_output_mode_b == OUT_NONINV |=> level_b ##1 compare_output_b_o)
		else $error("down match did not set");
	a_inv_up: assert property (@(posedge clk_i) disable iff (reset_i)
		timer_tick && match_a && !counting_down && !at_top &&
		compare_output_mode_a == OUT_INV |=> level_a ##1 compare_output_a_o)
		else $error("inverted up match did not set");
	a_tick_only: assert property (@(posedge clk_i) disable iff (reset_i)
		!timer_tick && !write_i |=> $stable(counter_value))
		else $error("counted without tick");
	a_controls_reset: assert property (@(posedge clk_i) $fell(reset_i) |->
		timer_control_a == 8'h00 && !compare_output_a_oe_o && !compare_output_b_oe_o)
		else $error("controls not cleared by reset");
endmodule // pwm_timer
`default_nettype wire

// [pwm_timer_tb_top.sv]
// Self-checking bench for the dual-slope PWM timer
// Assumes the timer package, map header and design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_map.svh"
`define check(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module pwm_timer_tb_top;
	import pwm_timer_pkg::*;
	logic       clk_i;
	logic       reset_i;
	logic [7:0] address_i;
	logic [7:0] write_data_i;
	logic       write_i;
	logic       read_i;
	logic [7:0] read_data_o;
	logic       pin_a;
	logic       oe_a;
	logic       pin_b;
	logic       oe_b;
	int         fails;
	int         samples_checked;

	pwm_timer pwm_timer_i (
		.clk_i                 (clk_i),
		.reset_i               (reset_i),
		.address_i             (address_i),
		.write_data_i          (write_data_i),
		.write_i               (write_i),
		.read_i                (read_i),
		.read_data_o           (read_data_o),
		.compare_output_a_o    (pin_a),
		.compare_output_a_oe_o (oe_a),
		.compare_output_b_o    (pin_b),
		.compare_output_b_oe_o (oe_b)
	);

	task automatic test_done();
		if (fails == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		write_i      <= 1'b1;
		address_i    <= a;
		write_data_i <= d;
		@(posedge clk_i);
		write_i <= 1'b0;
	endtask

	// High byte first: the low byte commits the word
	task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
		wr(lo + 8'h01, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		@(posedge clk_i);
		read_i    <= 1'b1;
		address_i <= a;
		@(posedge clk_i);
		read_i <= 1'b0;
		#1 d = read_data_o;
		`check(d, exp)
	endtask

	// Window must span whole periods so counts do not depend on phase
	task automatic measure(input int n, input logic ch, output logic [15:0] hi,
		output logic [15:0] rs);
		logic prev;
		logic cur;
		hi = 16'h0000;
		rs = 16'h0000;
		#1 prev = ch ? pin_b : pin_a;
		repeat (n) begin
			@(posedge clk_i);
			#1 cur = ch ? pin_b : pin_a;
			if (cur === 1'b1) hi++;
			if (cur === 1'b1 && prev === 1'b0) rs++;
			prev = cur;
		end
	endtask

	// Stopping first keeps the compare copies immediate and the counter parked at zero
	task automatic setup(input wave_mode_t m, input logic [15:0] top, input logic [15:0] ca,
		input logic [15:0] cb, input out_mode_t oa, input out_mode_t ob, input tick_select_e t);
		wr(`TIMER_CONTROL_B_OFFSET, 8'h00);
		wr16(`COUNTER_VALUE_LO_OFFSET, 16'h0000);
		wr16(`INPUT_CAPTURE_LO_OFFSET, top);
		wr16(`COMPARE_VALUE_A_LO_OFFSET, ca);
		wr16(`COMPARE_VALUE_B_LO_OFFSET, cb);
		wr(`TIMER_FLAGS_OFFSET, 8'hff);
		wr(`OUTPUT_DIRECTION_OFFSET, 8'h03);
		wr(`TIMER_CONTROL_A_OFFSET, {oa, ob, 2'h0, m[1:0]});
		wr(`TIMER_CONTROL_B_OFFSET, {3'h0, m[3:2], t});
	endtask

	task automatic t_reset();
		rd_check(`TIMER_CONTROL_A_OFFSET, 8'h00);
		`check({oe_a, oe_b}, 2'b00)
		wr(`TIMER_CONTROL_A_OFFSET, 8'hff);
		rd_check(`TIMER_CONTROL_A_OFFSET, 8'hf3);
		wr(`TIMER_CONTROL_B_OFFSET, 8'hf8);
		rd_check(`TIMER_CONTROL_B_OFFSET, 8'h18);
		rd_check(8'h00, 8'h00);
		wr(`TIMER_CONTROL_B_OFFSET, 8'h00);
		wr(`TIMER_CONTROL_A_OFFSET, 8'h00);
	endtask

	task automatic t_duty();
		logic [15:0] hi;
		logic [15:0] rs;
		for (int inv = 0; inv < 2; inv++) begin
			for (int i = 0; i <= 4; i++) begin
				setup(MODE_TOP_CAPTURE, 16'h0004, 16'(i), 16'h0000,
					inv ? OUT_INV : OUT_NONINV, 2'h0, TICK_DIV1);
				repeat (40) @(posedge clk_i);
				measure(64, 1'b0, hi, rs);
				`check(hi, inv ? 16'(64 - 16 * i) : 16'(16 * i))
				`check(rs, (i % 4 != 0) ? 16'h0008 : 16'h0000)
				`check(oe_a, 1'b1)
			end
		end
	endtask

	task automatic t_prescale();
		tick_select_e sel [5] = '{TICK_DIV1, TICK_DIV8, TICK_DIV64, TICK_DIV256, TICK_DIV1024};
		int           div [5] = '{1, 8, 64, 256, 1024};
		logic [15:0]  hi;
		logic [15:0]  rs;
		for (int k = 0; k < 5; k++) begin
			setup(MODE_TOP_CAPTURE, 16'h0004, 16'h0002, 16'h0000, OUT_NONINV, 2'h0, sel[k]);
			repeat (16 * div[k]) @(posedge clk_i);
			measure(16 * div[k], 1'b0, hi, rs);
			`check(hi, 16'(8 * div[k]))
			`check(rs, 16'h0002)
		end
	endtask

	task automatic t_toggle();
		logic [15:0] hi;
		logic [15:0] rs;
		setup(MODE_TOP_CAPTURE, 16'h0004, 16'h0002, 16'h0001, OUT_TOGGLE, 2'h0, TICK_DIV1);
		repeat (40) @(posedge clk_i);
		measure(64, 1'b0, hi, rs);
		`check(hi, 16'h0020)
		`check(rs, 16'h0008)
		wr(`TIMER_CONTROL_B_OFFSET, 8'h10);
		rd_check(`TIMER_FLAGS_OFFSET, 8'h27);
		wr(`TIMER_FLAGS_OFFSET, 8'hff);
		rd_check(`TIMER_FLAGS_OFFSET, 8'h00);
	endtask

	task automatic t_mode9();
		logic [15:0] hi;
		logic [15:0] rs;
		setup(MODE_TOP_COMPARE, 16'h0002, 16'h0006, 16'h0003, 2'h0, OUT_NONINV, TICK_DIV1);
		repeat (48) @(posedge clk_i);
		measure(48, 1'b1, hi, rs);
		`check(hi, 16'h0018)
		`check(rs, 16'h0004)
		`check({oe_a, oe_b}, 2'b01)
		wr(`TIMER_CONTROL_B_OFFSET, 8'h10);
		rd_check(`TIMER_FLAGS_OFFSET, 8'h07);
		wr(`OUTPUT_DIRECTION_OFFSET, 8'h00);
		repeat (3) @(posedge clk_i);
		`check(oe_b, 1'b0)
	endtask

	// Compare write while running: buffer reads back at once, output follows after bottom
	task automatic t_reload();
		logic [15:0] hi;
		logic [15:0] rs;
		setup(MODE_TOP_CAPTURE, 16'h0008, 16'h0000, 16'h0002, 2'h0, OUT_NONINV,
			TICK_DIV1);
		repeat (40) @(posedge clk_i);
		wr16(`COMPARE_VALUE_B_LO_OFFSET, 16'h0006);
		rd_check(`COMPARE_VALUE_B_LO_OFFSET, 8'h06);
		rd_check(`COMPARE_VALUE_B_HI_OFFSET, 8'h00);
		repeat (40) @(posedge clk_i);
		measure(32, 1'b1, hi, rs);
		`check(hi, 16'h0018)
		`check(rs, 16'h0002)
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		reset_i         = 1'b1;
		address_i       = 8'h00;
		write_data_i    = 8'h00;
		write_i         = 1'b0;
		read_i          = 1'b0;
		fails           = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_duty();
		t_prescale();
		t_toggle();
		t_mode9();
		t_reload();
		test_done();
	end

	// Longest scenario is the divide-by-1024 period, well under this span
	initial begin
		repeat (80000) @(posedge clk_i);
		fails++;
		test_done();
	end
endmodule // pwm_timer_tb_top
`default_nettype wire
